/* pkg/swd_pkg.sv */
// swd_pkg: constants for the wait-state descriptor slice of the parameter table
// assumes one 20 MHz core clock and an ahb-lite register bus
package swd_pkg;

  // ----------------------------------------------------------------
  // bus map
  // ----------------------------------------------------------------
  localparam logic [11:0] SWD_OFS_VOL   = 12'h378;
  localparam logic [11:0] SWD_OFS_NVOL  = 12'h37c;
  localparam logic [11:0] SWD_OFS_HIGH  = 12'h380;
  localparam logic [11:0] SWD_OFS_STAT  = 12'h3f0;
  localparam logic [11:0] SWD_OFS_CTRL  = 12'h3f4;

  // ----------------------------------------------------------------
  // descriptor fields
  // ----------------------------------------------------------------
  localparam logic [7:0] SWD_CMD_WRITE  = 8'h71;
  localparam logic [7:0] SWD_CMD_READ   = 8'h65;
  localparam logic [7:0] SWD_REG_ADDR   = 8'h04;
  localparam logic [0:0] SWD_SUPPORTED  = 1'h1;
  localparam logic [1:0] SWD_WID_VOL    = 2'h0;
  localparam logic [1:0] SWD_WID_NVOL   = 2'h2;
  localparam logic [0:0] SWD_BY_ADDR    = 1'h1;
  localparam logic [0:0] SWD_LAST_ADDR  = 1'h0;
  localparam logic [2:0] SWD_LSB_VOL    = 3'h4;
  localparam logic [2:0] SWD_LSB_NVOL   = 3'h0;
  localparam logic [4:0] SWD_PAT_NONE   = 5'h00;
  localparam logic [1:0] SWD_RSVD       = 2'h0;
  localparam int         SWD_SLOTS      = 5;
  localparam logic [4:0] SWD_LOW_CNT    = 5'h02;
  localparam logic [4:0] SWD_HIGH_CNT   = 5'h16;

  // ----------------------------------------------------------------
  // status and control
  // ----------------------------------------------------------------
  localparam logic [31:0] SWD_CTRL_RST  = 32'h0000_0000;
  localparam int          SWD_CTRL_LOCK = 0;

  typedef enum logic [1:0] {SWD_IDLE, SWD_DATA} swd_phase_t;

endpackage

/* logic/swd_table.sv */
// swd_table: read-only descriptor words for the wait-state setting, on ahb-lite
// assumes single word transfers from one master; hready fed back from o_hreadyout
//
// Operation
// - write command 71h reported in the low byte of both entries
// - read-back command 65h reported in bits 15 to 8
// - volatile field in volatile configuration register three at address 04h
// - volatile field two bits wide, width code 00b at bits 30:29
// - volatile field lsb at bit four, location code 100b
// - non-volatile field in non-volatile register three, also address 04h
// - non-volatile field four bits, width code 10b, lsb at bit zero
// - both copies selected by command address, not by dedicated commands
// - last-address-byte flag, bit 27, reads zero
// - variable dummy cycles supported; top bytes 94h and d0h
// - counts 22 to 30 reported unsupported, flags cleared
// - unsupported patterns 00000b, reserved bits 00b
// - counts 2 to 10 supported, pattern equals count in binary
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module swd_table
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [11:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp
);
  import swd_pkg::*;

  // ----------------------------------------------------------------
  // descriptor words
  // ----------------------------------------------------------------
  wire [31:0] vol_word  = {SWD_SUPPORTED, SWD_WID_VOL, SWD_BY_ADDR,
                           SWD_LAST_ADDR, SWD_LSB_VOL,
                           SWD_REG_ADDR, SWD_CMD_READ, SWD_CMD_WRITE};
  wire [31:0] nvol_word = {SWD_SUPPORTED, SWD_WID_NVOL, SWD_BY_ADDR,
                           SWD_LAST_ADDR, SWD_LSB_NVOL,
                           SWD_REG_ADDR, SWD_CMD_READ, SWD_CMD_WRITE};

  // five 6-bit slots (flag + pattern), slot 0 in bits 7:2, above reserved 1:0
  wire [29:0] high_slots;
  wire [29:0] low_slots;
  genvar g;
  generate
    for (g = 0; g < SWD_SLOTS; g++)
    begin : g_slot
      // slot 4 (bits 31:26) is the largest count of the word
      assign high_slots[g*6 +: 6] = {1'b0, SWD_PAT_NONE};
      assign low_slots[g*6 +: 6]  = {SWD_SUPPORTED,
                                     5'(SWD_LOW_CNT + 5'(2 * g))};
    end
  endgenerate
  wire [31:0] high_word = {high_slots, SWD_RSVD};
  // low-count word (counts 2 to 10) is not on the bus map; assertions pin its layout
  wire [31:0] low_word  = {low_slots, SWD_RSVD};

  // ----------------------------------------------------------------
  // status and control (own registers)
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] wr_drop_r;

  // ----------------------------------------------------------------
  // address phase
  // ----------------------------------------------------------------
  wire        take     = i_hsel & i_hready & i_htrans[1];
  logic       pend_r;
  logic       pend_wr_r;
  logic [11:0] pend_addr_r;
  swd_phase_t phase_r;

  wire sel_vol  = pend_addr_r == SWD_OFS_VOL;
  wire sel_nvol = pend_addr_r == SWD_OFS_NVOL;
  wire sel_high = pend_addr_r == SWD_OFS_HIGH;
  wire sel_stat = pend_addr_r == SWD_OFS_STAT;
  wire sel_ctrl = pend_addr_r == SWD_OFS_CTRL;

  // fixed content per descriptor word address, live status and control words; unmapped reads return zero
  wire [31:0] rd_mux = sel_vol  ? vol_word  :
                       sel_nvol ? nvol_word :
                       sel_high ? high_word :
                       sel_stat ? {16'h0000, wr_drop_r} :
                       sel_ctrl ? ctrl_r : 32'h0000_0000;
  wire rd_fire = take & ~i_hwrite;
  wire wr_data = pend_r & pend_wr_r;
  // writes to any address but the control word count as dropped
  wire wr_drop = wr_data & ~sel_ctrl;
  // next values feed the read mux as well, so a read issued in the data
  // phase of a write already sees what that write leaves behind
  wire        ctrl_wr     = wr_data & sel_ctrl & ~ctrl_r[SWD_CTRL_LOCK];
  wire        drop_inc    = wr_drop & (wr_drop_r != 16'hffff);
  wire [31:0] ctrl_nxt    = ctrl_wr ? i_hwdata : ctrl_r;
  wire [15:0] wr_drop_nxt = drop_inc ? wr_drop_r + 16'h0001 : wr_drop_r;

  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;

  // read data must be present in the data phase: mux on the live address
  wire [31:0] rd_live = (i_haddr == SWD_OFS_VOL)  ? vol_word  :
                        (i_haddr == SWD_OFS_NVOL) ? nvol_word :
                        (i_haddr == SWD_OFS_HIGH) ? high_word :
                        (i_haddr == SWD_OFS_STAT) ? {16'h0000, wr_drop_nxt} :
                        (i_haddr == SWD_OFS_CTRL) ? ctrl_nxt : 32'h0000_0000;
  assign hrdata_nxt = rd_fire ? rd_live : hrdata_r;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      pend_r      <= 1'b0;
      pend_wr_r   <= 1'b0;
      pend_addr_r <= 12'h000;
      phase_r     <= SWD_IDLE;
      hrdata_r    <= 32'h0000_0000;
    end
    else
    begin
      pend_r      <= take;
      pend_wr_r   <= take & i_hwrite;
      pend_addr_r <= take ? i_haddr : pend_addr_r;
      phase_r     <= take ? SWD_DATA : SWD_IDLE;
      hrdata_r    <= hrdata_nxt;
    end
  end

  // control word is writable unless its lock bit is already set
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ctrl_r    <= SWD_CTRL_RST;
      wr_drop_r <= 16'h0000;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      wr_drop_r <= wr_drop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs: zero wait states, always okay
  // ----------------------------------------------------------------
  always_comb
  begin
    case (phase_r)
      SWD_IDLE: o_hrdata = hrdata_r;
      SWD_DATA: o_hrdata = hrdata_r;
      default:  o_hrdata = hrdata_r;
    endcase
  end
  // ready and response leave flops too, so no output hangs on a tie-off
  logic hreadyout_r;
  logic hresp_r;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end
  assign o_hreadyout = hreadyout_r;
  assign o_hresp     = hresp_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_read_vol;
    take && !i_hwrite && i_haddr == SWD_OFS_VOL;
  endsequence
  sequence s_read_nvol;
    take && !i_hwrite && i_haddr == SWD_OFS_NVOL;
  endsequence
  sequence s_read_high;
    take && !i_hwrite && i_haddr == SWD_OFS_HIGH;
  endsequence
  // address phases only; the word is looked at one edge later,
  // when the master takes it
  sequence s_read_stat;
    take && !i_hwrite && i_haddr == SWD_OFS_STAT;
  endsequence
  sequence s_read_hole;
    take && !i_hwrite && i_haddr != SWD_OFS_VOL && i_haddr != SWD_OFS_NVOL &&
    i_haddr != SWD_OFS_HIGH && i_haddr != SWD_OFS_STAT && i_haddr != SWD_OFS_CTRL;
  endsequence
  sequence s_write_table;
    take && i_hwrite && i_haddr != SWD_OFS_CTRL;
  endsequence
  sequence s_write_ctrl;
    take && i_hwrite && i_haddr == SWD_OFS_CTRL;
  endsequence

  a_vol_cmds: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_vol |=> o_hrdata[7:0] == 8'h71 && o_hrdata[15:8] == 8'h65)
    else $error("volatile entry command bytes wrong");
  a_nvol_cmds: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_nvol |=> o_hrdata[15:8] == 8'h65 && o_hrdata[7:0] == 8'h71)
    else $error("non-volatile entry command bytes wrong");
  a_vol_regaddr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_vol |=> o_hrdata[23:16] == 8'h04)
    else $error("volatile register address wrong");
  a_vol_top: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_vol |=> o_hrdata[31:24] == 8'h94 && o_hrdata[30:29] == 2'b00)
    else $error("volatile top byte wrong");
  a_vol_lsb: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_vol |=> o_hrdata[26:24] == 3'b100 && !o_hrdata[27])
    else $error("volatile lsb location wrong");
  a_nvol_top: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_nvol |=> o_hrdata[31:24] == 8'hd0 && o_hrdata[23:16] == 8'h04)
    else $error("non-volatile top byte wrong");
  a_high_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_high |=> o_hrdata == 32'h0000_0000)
    else $error("high counts not reported unsupported");
  a_low_pattern: assert property (@(posedge i_core_clk) disable iff (i_rst)
    low_word == 32'haa89_a488 ##1 low_word[13:8] == 6'h24)
    else $error("low count slots wrong");
  a_write_inert: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take && i_hwrite && i_haddr == SWD_OFS_VOL ##1 1'b1
      |=> $stable(ctrl_r) && vol_word == 32'h9404_6571)
    else $error("descriptor write had an effect");
  a_always_ready: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take |=> o_hreadyout && !o_hresp [*2])
    else $error("slave stalled or erred");

  // ----------------------------------------------------------------
  // field-by-field checks of the two register-map entries
  // ----------------------------------------------------------------
  a_vol_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_vol |=> o_hrdata[30:29] == 2'b00)
    else $error("volatile field width code wrong");

  a_vol_by_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_vol |=> o_hrdata[28])
    else $error("volatile entry not reached by address");

  a_nvol_regaddr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_nvol |=> o_hrdata[23:16] == 8'h04)
    else $error("non-volatile register address wrong");

  a_nvol_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_nvol |=> o_hrdata[30:29] == 2'b10 && o_hrdata[26:24] == 3'b000)
    else $error("non-volatile width or lsb code wrong");

  a_nvol_by_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_nvol |=> o_hrdata[28])
    else $error("non-volatile entry not reached by address");

  a_nvol_last_addr: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_nvol |=> !o_hrdata[27])
    else $error("non-volatile last-address flag set");

  a_nvol_support: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_nvol |=> o_hrdata[31])
    else $error("non-volatile entry lost its support bit");

  // ----------------------------------------------------------------
  // unsupported and supported count slots
  // ----------------------------------------------------------------
  a_high_flags: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_high |=> !o_hrdata[31] && !o_hrdata[25] && !o_hrdata[19] &&
                    !o_hrdata[13] && !o_hrdata[7])
    else $error("an unsupported count reads as supported");

  a_high_patterns: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_high |=> o_hrdata[30:26] == 5'b00000 && o_hrdata[24:20] == 5'b00000 &&
                    o_hrdata[18:14] == 5'b00000 && o_hrdata[12:8] == 5'b00000 &&
                    o_hrdata[6:2] == 5'b00000 && o_hrdata[1:0] == 2'b00)
    else $error("unsupported pattern or reserved bits not zero");

  // the low-count word never reaches the bus, so its layout is pinned here
  a_low_two: assert property (@(posedge i_core_clk) disable iff (i_rst)
    low_word[7:2] == 6'h22)
    else $error("two-cycle slot wrong");

  a_low_ten: assert property (@(posedge i_core_clk) disable iff (i_rst)
    low_word[31:26] == 6'h2a)
    else $error("ten-cycle slot wrong");

  // ----------------------------------------------------------------
  // read path, holes and the own registers
  // ----------------------------------------------------------------
  a_read_holds: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !rd_fire |=> $stable(o_hrdata))
    else $error("read data moved without a read");

  // the data-phase word must agree with the decode of the latched address;
  // this catches a read issued right behind a write that changes the word
  a_read_matches: assert property (@(posedge i_core_clk) disable iff (i_rst)
    pend_r && !pend_wr_r |-> o_hrdata == rd_mux)
    else $error("read data disagrees with the latched address");

  a_hole_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_hole |=> o_hrdata == 32'h0000_0000)
    else $error("unmapped address read as non-zero");

  a_drop_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_write_table ##1 wr_drop_r != 16'hffff
      |=> wr_drop_r == $past(wr_drop_r) + 16'h0001)
    else $error("dropped write not counted");

  a_drop_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !wr_drop |=> $stable(wr_drop_r))
    else $error("drop count moved without a dropped write");

  a_stat_upper: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_read_stat |=> o_hrdata[31:16] == 16'h0000)
    else $error("status upper half not zero");

  a_ctrl_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_write_ctrl ##1 !ctrl_r[SWD_CTRL_LOCK] |=> ctrl_r == $past(i_hwdata))
    else $error("control write not taken");

  a_ctrl_locked: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_write_ctrl ##1 ctrl_r[SWD_CTRL_LOCK] |=> $stable(ctrl_r))
    else $error("locked control word changed");

  a_ctrl_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(pend_r && pend_wr_r && sel_ctrl) |=> $stable(ctrl_r))
    else $error("control word moved without a control write");

  a_ctrl_no_drop: assert property (@(posedge i_core_clk) disable iff (i_rst)
    s_write_ctrl ##1 1'b1 |=> $stable(wr_drop_r))
    else $error("control write counted as dropped");

  a_phase_data: assert property (@(posedge i_core_clk) disable iff (i_rst)
    take |=> phase_r == SWD_DATA && pend_r)
    else $error("data phase not entered after a taken transfer");

endmodule

/* dv/swd_host.sv */
// swd_host: ahb-lite master that stands in for the host reading the table
// assumes hready is the slave's hreadyout and one word per transfer
`timescale 1ns/1ps
module swd_host
(
  // clock and bus return
  input  wire logic        i_core_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  // bus request
  output logic             o_hsel,
  output logic      [11:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [31:0] o_hwdata
);
  initial
  begin
    o_hsel   = 1'b0;
    o_haddr  = 12'h000;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize  = 3'h2;
    o_hwdata = 32'h0000_0000;
  end

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy(inout bit to);
    int n;
    n = 0;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (i_hready !== 1'b1 && n < 64);
    if (i_hready !== 1'b1)
      to = 1'b1;
  endtask

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output bit to);
    to = 1'b0;
    @(posedge i_core_clk);
    o_hsel   <= 1'b1;
    o_haddr  <= a;
    o_htrans <= 2'h2;
    o_hwrite <= wr;
    o_hsize  <= 3'h2;
    wait_rdy(to);
    o_hsel   <= 1'b0;
    o_htrans <= 2'h0;
    o_haddr  <= ~a;
    o_hwdata <= wd;
    wait_rdy(to);
    rd = i_hrdata;
    // released data lines show the inverse, never the stale word
    o_hwdata <= ~wd;
  endtask
endmodule

/* dv/sfdp_wait_state_descriptor_test.sv */
// sfdp_wait_state_descriptor_test: register sequences against the descriptor table
// assumes the table answers on ahb-lite with hready looped back
`timescale 1ns/1ps
module sfdp_wait_state_descriptor_test;
  import swd_pkg::*;
  localparam logic [31:0] VOL_W  = {1'b1, 2'b00, 1'b1, 1'b0, 3'b100, 8'h04, 8'h65, 8'h71};
  localparam logic [31:0] NVOL_W = {1'b1, 2'b10, 1'b1, 1'b0, 3'b000, 8'h04, 8'h65, 8'h71};
  localparam logic [31:0] HIGH_W = {{5{6'h00}}, 2'b00};
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  int          error_cnt = 0;
  int          tests_run = 0;

  initial
  begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  swd_host u_swd_host (.i_core_clk(i_core_clk), .i_hready(hready), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata));
  swd_table u_swd_table (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic go(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    bit to;
    u_swd_host.xfer(wr, a, wd, rd, to);
    chk({31'h0, hresp}, 32'h0);
    if (to)
    begin
      error_cnt++;
      stop_test();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    go(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    go(1'b1, a, wd, d);
  endtask

  task automatic reset_dut();
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    @(posedge i_core_clk);
    #1;
    chk({30'h0, hready, hresp}, 32'h2);
    chk(hrdata, 32'h0);
    @(posedge i_core_clk);
    i_rst <= 1'b0;
  endtask

  initial
  begin
    reset_dut();
    rd_chk(SWD_OFS_STAT, 32'h0);
    rd_chk(SWD_OFS_CTRL, 32'h0);
    rd_chk(SWD_OFS_VOL, VOL_W);
    rd_chk(SWD_OFS_NVOL, NVOL_W);
    rd_chk(SWD_OFS_HIGH, HIGH_W);
    // ---------------------------------------------------------------
    // writes into the table must leave every byte as it was
    // ---------------------------------------------------------------
    wr_reg(SWD_OFS_VOL, 32'hffff_ffff);
    wr_reg(SWD_OFS_NVOL, 32'h0000_0000);
    wr_reg(SWD_OFS_HIGH, 32'h5555_aaaa);
    wr_reg(12'h100, 32'hdead_beef);
    rd_chk(SWD_OFS_VOL, VOL_W);
    rd_chk(SWD_OFS_NVOL, NVOL_W);
    rd_chk(SWD_OFS_HIGH, HIGH_W);
    rd_chk(12'h100, 32'h0);
    rd_chk(SWD_OFS_STAT, 32'h4);
    // ---------------------------------------------------------------
    // control scratch and its lock
    // ---------------------------------------------------------------
    wr_reg(SWD_OFS_CTRL, 32'h5a5a_5a5a);
    rd_chk(SWD_OFS_CTRL, 32'h5a5a_5a5a);
    wr_reg(SWD_OFS_CTRL, 32'h0000_00a1);
    wr_reg(SWD_OFS_CTRL, 32'h1234_5678);
    rd_chk(SWD_OFS_CTRL, 32'h0000_00a1);
    rd_chk(SWD_OFS_STAT, 32'h4);
    // second reset in mid-run clears lock and count, table unchanged
    reset_dut();
    rd_chk(SWD_OFS_CTRL, 32'h0);
    rd_chk(SWD_OFS_STAT, 32'h0);
    rd_chk(SWD_OFS_VOL, VOL_W);
    stop_test();
  end
endmodule
